/* charger_qualification_fsm_tb.sv */
// charger_qualification_fsm_tb: table walk through the charge states, then reset and probe
// assumes: chqf_fsm and chqf_batt_model compiled, inputs driven on falling edges
`timescale 1ns/100ps
module charger_qualification_fsm_tb;
   typedef struct packed {logic [13:0] cmp; chqf_pkg::chqf_state_t st; logic [4:0] outs;} chqf_row_t;
   logic                 clk, rst, te_n, pin_a, pin_b, a_oe, b_oe, pg_oe, charge_on, precond, a0, pg0, seen_a, seen_pg, tfault;
   chqf_pkg::chqf_cmp_t  cmp;
   chqf_pkg::chqf_state_t o_state;
   int                   n_mismatch = 0;
   int                   comparisons = 0;
   // outs: a_oe b_oe pg_oe charge_on precond
   chqf_row_t rows [16] = '{'{14'h3F60, chqf_pkg::ST_PRECOND, 5'h17}, '{14'h3FE0, chqf_pkg::ST_FAST, 5'h16},
      '{14'h3FE1, chqf_pkg::ST_CV, 5'h16}, '{14'h3FE5, chqf_pkg::ST_DONE, 5'h0C},
      '{14'h3FE2, chqf_pkg::ST_FAST, 5'h16}, '{14'h3FA2, chqf_pkg::ST_TEMP_FAULT, 5'h04},
      '{14'h3FE2, chqf_pkg::ST_FAST, 5'h16}, '{14'h3FEA, chqf_pkg::ST_STANDBY, 5'h04},
      '{14'h3EF2, chqf_pkg::ST_SYS_TEST, 5'h1E}, '{14'h36F2, chqf_pkg::ST_SHUTDOWN, 5'h00},
      '{14'h2F60, chqf_pkg::ST_SHUTDOWN, 5'h00}, '{14'h3F60, chqf_pkg::ST_PRECOND, 5'h17},
      '{14'h3F40, chqf_pkg::ST_TEMP_FAULT, 5'h04}, '{14'h3FE1, chqf_pkg::ST_CV, 5'h16},
      '{14'h3BEA, chqf_pkg::ST_STANDBY, 5'h00}, '{14'h3F60, chqf_pkg::ST_PRECOND, 5'h17}};
   chqf_fsm u_dut (.i_clk_sys(clk), .i_rst(rst), .i_cmp(cmp), .i_timer_enable_n(te_n),
      .i_charge_status_a(pin_a), .i_charge_status_b(pin_b), .o_charge_status_a(), .o_charge_status_a_oe(a_oe),
      .o_charge_status_b(), .o_charge_status_b_oe(b_oe), .o_input_power_good(), .o_input_power_good_oe(pg_oe),
      .o_state(o_state), .o_charge_on(charge_on), .o_precond_current(precond), .o_timer_fault(tfault));
   chqf_batt_model u_batt (.i_a_oe(a_oe), .i_b_oe(b_oe), .o_pin_a(pin_a), .o_pin_b(pin_b));
   // free-running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // bounded wait; a miss ends the run
   task automatic wait_state(input chqf_pkg::chqf_state_t st);
      int n = 0;
      repeat (6) @(negedge clk);
      while (o_state !== st && n < 60) begin
         @(negedge clk);
         n++;
      end
      if (o_state !== st) begin
         n_mismatch++;
         $display("Error state wait expected %h seen %h", st, o_state);
         close_out();
      end
   endtask
   // main sequence
   initial begin
      rst = 1'b1;
      te_n = 1'b0;
      cmp = '0;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      repeat (6) @(negedge clk);
      for (int i = 0; i < 16; i++) begin
         cmp = rows[i].cmp; // current set floats in two rows
         te_n = i[0]; // host turns the timer off on odd rows
         wait_state(rows[i].st);
         check("state", 8'(o_state), 8'(rows[i].st));
         check("outputs", {3'h0, a_oe, b_oe, pg_oe, charge_on, precond}, {3'h0, rows[i].outs});
         check("pin a", {7'h0, pin_a}, {7'h0, ~rows[i].outs[4]});
         check("pin b", {7'h0, pin_b}, {7'h0, ~rows[i].outs[3]});
         check("timer fault", {7'h0, tfault}, {7'h0, rows[i].st == chqf_pkg::ST_TIMER_FAULT});
      end
      $display("test table done");
      // reset in mid-charge must drop everything; new levels go in during reset so the
      // synchroniser holds them, not the pre-reset ones, at the first edge after release
      rst = 1'b1;
      cmp = 14'h3D60;
      repeat (2) @(negedge clk);
      check("reset", {o_state, a_oe, pg_oe, charge_on, precond}, 8'(chqf_pkg::ST_SHUTDOWN) << 4);
      $display("test reset done");
      // low supply margin: stay in standby and blink status a and power good
      rst = 1'b0;
      wait_state(chqf_pkg::ST_STANDBY);
      a0 = a_oe;
      pg0 = pg_oe;
      seen_a = 1'b0;
      seen_pg = 1'b0;
      for (int n = 0; n < 12000; n++) begin
         @(negedge clk);
         seen_a |= (a_oe !== a0);
         seen_pg |= (pg_oe !== pg0);
      end
      check("probe", {6'h0, seen_a, seen_pg}, 8'h03);
      check("probe state", 8'(o_state), 8'(chqf_pkg::ST_STANDBY));
      $display("test probe done");
      close_out();
   end
endmodule
bind chqf_fsm chqf_fsm_monitor u_mon (.i_clk_sys, .i_rst, .i_cmp, .o_charge_status_a, .o_charge_status_b,
   .o_input_power_good, .o_charge_status_a_oe, .o_charge_status_b_oe, .o_input_power_good_oe, .o_state,
   .o_charge_on, .o_precond_current, .o_timer_fault);

/* chqf_batt_model.sv */
// chqf_batt_model: far side with pull-ups or leds on the open-drain pins
// assumes: an enable high means the charger sinks the pin
`timescale 1ns/100ps
module chqf_batt_model (
   // sink enables from the charger
   input  wire logic i_a_oe,
   input  wire logic i_b_oe,
   // resolved pin levels
   output logic      o_pin_a,
   output logic      o_pin_b
);
   // pull-up gives the high level, the charger can only sink
   assign o_pin_a = i_a_oe ? 1'b0 : 1'b1;
   assign o_pin_b = i_b_oe ? 1'b0 : 1'b1;
endmodule

/* chqf_fsm.sv */
// chqf_fsm: charge qualification and status state machine
// assumes: comparator results arrive unsynchronised; open-drain pads outside resolve pins
//
// Function
// - stay shut down until supply passes lockout
// - leave shutdown only above battery plus 150mV
// - force shutdown below lockout or near battery
// - charge needs lockout met and battery present
// - floating current set disables charging
// - pulse status a and power good probing
// - below precondition threshold enter preconditioning
// - above threshold move to fast charge
// - timer runs only while enable pin low
// - power good low above lockout and battery
// - status outputs are open drain only
// - thermistor normal between 0.25V and 1.20V
// - temperature out of range suspends, freezes timer
// - timer cleared on fast charge entry, except on resume from temperature fault
// - status encoding per charge state
// - timer expiry in fast charge latches fault until removal; in constant voltage it ends the charge
`timescale 1ns/100ps
module chqf_fsm (
   // clock and reset
   input  wire logic                i_clk_sys,
   input  wire logic                i_rst,
   // analog comparator results and pins
   input  wire chqf_pkg::chqf_cmp_t i_cmp,
   input  wire logic                i_timer_enable_n,
   // open-drain status pins: level in, drive low enable out
   input  wire logic                i_charge_status_a,
   input  wire logic                i_charge_status_b,
   output logic                     o_charge_status_a,
   output logic                     o_charge_status_a_oe,
   output logic                     o_charge_status_b,
   output logic                     o_charge_status_b_oe,
   output logic                     o_input_power_good,
   output logic                     o_input_power_good_oe,
   // state and control to the analog core
   output chqf_pkg::chqf_state_t    o_state,
   output logic                     o_charge_on,
   output logic                     o_precond_current,
   output logic                     o_timer_fault
);
   chqf_pkg::chqf_cmp_t   cmp;
   chqf_pkg::chqf_state_t state;
   chqf_pkg::chqf_state_t next_state;
   logic [chqf_pkg::PROBE_W-1:0] probe_cnt;
   logic                         probe_phase;
   logic [chqf_pkg::TICK_W-1:0]  tick_cnt;
   logic                         tick;
   logic [chqf_pkg::TIMER_W-1:0] timer;
   logic                         timer_exp;
   logic                         temp_ok;
   logic                         supply_ok;
   logic                         next_a;
   logic                         next_b;
   logic                         next_pg;

   // comparators cross through two flops before any use
   chqf_sync #(.W(chqf_pkg::CMP_W)) u_sync (
      .i_clk_sys (i_clk_sys),
      .i_async   (i_cmp),
      .o_sync    (cmp)
   );

   // supply qualification and thermistor window
   assign supply_ok = cmp.undervoltage_lockout_ok & cmp.pd_ok;
   assign temp_ok   = cmp.battery_temp_input_hi_ok & cmp.battery_temp_input_lo_ok;
   assign timer_exp = (timer >= chqf_pkg::TIMER_LIMIT);

   // state register; reset lands in shutdown
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         state <= chqf_pkg::ST_SHUTDOWN;
      end else begin
         state <= next_state;
      end
   end

   // next state; supply loss overrides every state
   always_comb begin
      next_state = state;
      case (state)
         chqf_pkg::ST_SHUTDOWN: begin
            if (cmp.undervoltage_lockout_ok && cmp.exit_ok) begin
               next_state = chqf_pkg::ST_STANDBY;
            end
         end
         chqf_pkg::ST_STANDBY: begin
            if (cmp.battery_temp_input_test && !cmp.bat_present) begin
               next_state = chqf_pkg::ST_SYS_TEST;
            end else if (cmp.bat_present && !cmp.iset_open && cmp.vdd_gt_reg) begin
               next_state = cmp.bat_above_pre ? chqf_pkg::ST_FAST : chqf_pkg::ST_PRECOND;
            end
         end
         chqf_pkg::ST_PRECOND: begin
            if (!temp_ok) begin
               next_state = chqf_pkg::ST_TEMP_FAULT;
            end else if (cmp.bat_above_pre) begin
               next_state = chqf_pkg::ST_FAST;
            end
         end
         chqf_pkg::ST_FAST: begin
            if (!temp_ok) begin
               next_state = chqf_pkg::ST_TEMP_FAULT;
            end else if (timer_exp) begin
               next_state = chqf_pkg::ST_TIMER_FAULT;
            end else if (cmp.at_reg) begin
               next_state = chqf_pkg::ST_CV;
            end
         end
         chqf_pkg::ST_CV: begin
            if (!temp_ok) begin
               next_state = chqf_pkg::ST_TEMP_FAULT;
            end else if (cmp.term_done || timer_exp) begin
               next_state = chqf_pkg::ST_DONE;
            end
         end
         chqf_pkg::ST_DONE: begin
            if (cmp.recharge) begin
               next_state = chqf_pkg::ST_FAST;
            end
         end
         chqf_pkg::ST_TEMP_FAULT: begin
            // resume into whichever phase the battery voltage calls for
            if (temp_ok) begin
               next_state = cmp.bat_above_pre ? (cmp.at_reg ? chqf_pkg::ST_CV : chqf_pkg::ST_FAST)
                                              : chqf_pkg::ST_PRECOND;
            end
         end
         chqf_pkg::ST_TIMER_FAULT: begin
            next_state = chqf_pkg::ST_TIMER_FAULT;
         end
         chqf_pkg::ST_SYS_TEST: begin
            if (!cmp.battery_temp_input_test) begin
               next_state = chqf_pkg::ST_STANDBY;
            end
         end
         default: next_state = chqf_pkg::ST_SHUTDOWN;
      endcase
      // removal or manual shutdown drops back to standby
      if (state != chqf_pkg::ST_SHUTDOWN && state != chqf_pkg::ST_STANDBY &&
          state != chqf_pkg::ST_SYS_TEST && (cmp.iset_open || !cmp.bat_present)) begin
         next_state = chqf_pkg::ST_STANDBY;
      end
      if (!supply_ok) begin
         next_state = chqf_pkg::ST_SHUTDOWN;
      end
   end

   // probe pulse divider: toggles a phase flag each probe period
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         probe_cnt   <= '0;
         probe_phase <= 1'b0;
      end else if (probe_cnt == chqf_pkg::PROBE_W'(chqf_pkg::PROBE_CYCLES - 1)) begin
         probe_cnt   <= '0;
         probe_phase <= ~probe_phase;
      end else begin
         probe_cnt <= probe_cnt + 1'b1;
      end
   end

   // 1 ms tick enable for the charge timer
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         tick_cnt <= '0;
         tick     <= 1'b0;
      end else begin
         tick <= (tick_cnt == chqf_pkg::TICK_W'(chqf_pkg::TICK_CYCLES - 1));
         if (tick_cnt == chqf_pkg::TICK_W'(chqf_pkg::TICK_CYCLES - 1)) begin
            tick_cnt <= '0;
         end else begin
            tick_cnt <= tick_cnt + 1'b1;
         end
      end
   end

   // charge timer: cleared on fast entry, frozen in temperature fault
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         timer <= '0;
      end else if (next_state == chqf_pkg::ST_FAST && state != chqf_pkg::ST_FAST &&
                   state != chqf_pkg::ST_TEMP_FAULT) begin
         timer <= '0;
      end else if (tick && !i_timer_enable_n && !timer_exp &&
                   (state == chqf_pkg::ST_FAST || state == chqf_pkg::ST_CV)) begin
         timer <= timer + 1'b1;
      end
   end

   // status encoding; asserted value means pin pulled low
   always_comb begin
      next_a  = 1'b0;
      next_b  = 1'b0;
      next_pg = cmp.undervoltage_lockout_ok & cmp.vdd_gt_bat;
      case (next_state)
         chqf_pkg::ST_PRECOND,
         chqf_pkg::ST_FAST,
         chqf_pkg::ST_CV:       next_a = 1'b1;
         chqf_pkg::ST_DONE:     next_b = 1'b1;
         chqf_pkg::ST_SYS_TEST: begin
            next_a = 1'b1;
            next_b = 1'b1;
         end
         chqf_pkg::ST_SHUTDOWN: next_pg = 1'b0;
         default: begin
            next_a = 1'b0;
         end
      endcase
      // low supply: blink while probing for a battery
      if (next_state == chqf_pkg::ST_STANDBY && cmp.undervoltage_lockout_ok && !cmp.vdd_gt_reg) begin
         next_a  = probe_phase;
         next_pg = probe_phase;
      end
   end

   // open-drain pads only ever sink; data held low, enable does the work
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_charge_status_a_oe  <= chqf_pkg::RST_OUT_OFF;
         o_charge_status_b_oe  <= chqf_pkg::RST_OUT_OFF;
         o_input_power_good_oe <= chqf_pkg::RST_OUT_OFF;
      end else begin
         o_charge_status_a_oe  <= next_a;
         o_charge_status_b_oe  <= next_b;
         o_input_power_good_oe <= next_pg;
      end
   end

   // constant low data for the open-drain pads
   always_ff @(posedge i_clk_sys) begin
      o_charge_status_a  <= 1'b0;
      o_charge_status_b  <= 1'b0;
      o_input_power_good <= 1'b0;
   end

   // controls to the analog core
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_state           <= chqf_pkg::ST_SHUTDOWN;
         o_charge_on       <= 1'b0;
         o_precond_current <= 1'b0;
         o_timer_fault     <= 1'b0;
      end else begin
         o_state           <= next_state;
         o_charge_on       <= (next_state == chqf_pkg::ST_PRECOND) || (next_state == chqf_pkg::ST_FAST) ||
                              (next_state == chqf_pkg::ST_CV) || (next_state == chqf_pkg::ST_SYS_TEST);
         o_precond_current <= (next_state == chqf_pkg::ST_PRECOND);
         o_timer_fault     <= (next_state == chqf_pkg::ST_TIMER_FAULT);
      end
   end
endmodule

/* chqf_fsm_monitor.sv */
// chqf_fsm_monitor: port-level checks on the charger state machine
// assumes: bound to chqf_fsm, single clock, synchronous active-high reset
`timescale 1ns/100ps
module chqf_fsm_monitor (
   // clock and reset
   input wire logic                  i_clk_sys,
   input wire logic                  i_rst,
   // comparator levels
   input wire chqf_pkg::chqf_cmp_t   i_cmp,
   // outputs watched
   input wire logic                  o_charge_status_a,
   input wire logic                  o_charge_status_b,
   input wire logic                  o_input_power_good,
   input wire logic                  o_charge_status_a_oe,
   input wire logic                  o_charge_status_b_oe,
   input wire logic                  o_input_power_good_oe,
   input wire chqf_pkg::chqf_state_t o_state,
   input wire logic                  o_charge_on,
   input wire logic                  o_precond_current,
   input wire logic                  o_timer_fault
);
   default clocking mon_cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);
   // charging states share one status encoding
   logic charging;
   assign charging = o_state inside {chqf_pkg::ST_PRECOND, chqf_pkg::ST_FAST, chqf_pkg::ST_CV};
   // four samples leave room for the two sync flops plus the output register
   property p_undervoltage_lockout;
      (!i_cmp.undervoltage_lockout_ok)[*4] |=> o_state == chqf_pkg::ST_SHUTDOWN;
   endproperty
   a_undervoltage_lockout: assert property (p_undervoltage_lockout) else $error("lockout did not force shutdown");
   property p_near_bat;
      (!i_cmp.pd_ok)[*4] |=> o_state == chqf_pkg::ST_SHUTDOWN;
   endproperty
   a_near_bat: assert property (p_near_bat) else $error("supply near battery did not force shutdown");
   property p_exit;
      (o_state == chqf_pkg::ST_SHUTDOWN && !i_cmp.exit_ok)[*4] |=> o_state == chqf_pkg::ST_SHUTDOWN;
   endproperty
   a_exit: assert property (p_exit) else $error("left shutdown without exit margin");
   sequence s_start;
      (o_state == chqf_pkg::ST_STANDBY) ##1 (o_state == chqf_pkg::ST_PRECOND || o_state == chqf_pkg::ST_FAST);
   endsequence
   property p_qualify;
      s_start |-> $past(i_cmp.bat_present, 2) || $past(i_cmp.bat_present, 3) || $past(i_cmp.bat_present, 4);
   endproperty
   a_qualify: assert property (p_qualify) else $error("charge began with no battery");
   property p_iset;
      (i_cmp.iset_open)[*5] |=> !charging;
   endproperty
   a_iset: assert property (p_iset) else $error("charging with current set open");
   sequence s_hot_in_fast;
      (o_state == chqf_pkg::ST_FAST && !i_cmp.battery_temp_input_hi_ok) ##1 (!i_cmp.battery_temp_input_hi_ok)[*3];
   endsequence
   property p_temp;
      s_hot_in_fast |=> !o_charge_on;
   endproperty
   a_temp: assert property (p_temp) else $error("charge kept on out of temperature");
   property p_charging;
      charging |-> o_charge_status_a_oe && !o_charge_status_b_oe && o_charge_on && o_input_power_good_oe;
   endproperty
   a_charging: assert property (p_charging) else $error("charging status encoding wrong");
   property p_done;
      o_state == chqf_pkg::ST_DONE |-> o_charge_status_b_oe && !o_charge_status_a_oe && !o_charge_on;
   endproperty
   a_done: assert property (p_done) else $error("complete status encoding wrong");
   property p_off;
      o_state == chqf_pkg::ST_SHUTDOWN |-> !o_input_power_good_oe && !o_charge_status_a_oe && !o_charge_on;
   endproperty
   a_off: assert property (p_off) else $error("shutdown drives a pin");
   property p_drain;
      !o_charge_status_a && !o_charge_status_b && !o_input_power_good;
   endproperty
   a_drain: assert property (p_drain) else $error("status pin driven high");
   property p_modes;
      o_precond_current == (o_state == chqf_pkg::ST_PRECOND) && o_timer_fault == (o_state == chqf_pkg::ST_TIMER_FAULT);
   endproperty
   a_modes: assert property (p_modes) else $error("mode flag disagrees with state");
endmodule

/* chqf_pkg.sv */
// chqf_pkg: shared types and constants for the charger qualification state machine
// assumes: one 100 MHz clock; comparator inputs come from the analog front end
package chqf_pkg;
   // comparator bundle from the analog front end
   typedef struct packed {
      logic undervoltage_lockout_ok;        // supply above lockout trip, 100 mV hysteresis applied in the comparator
      logic exit_ok;        // supply above battery plus 150 mV
      logic pd_ok;          // supply above battery plus 50 mV
      logic vdd_gt_bat;     // supply above battery voltage
      logic vdd_gt_reg;     // supply above regulation voltage plus 0.3 V
      logic bat_present;    // battery or load seen on battery_output
      logic bat_above_pre;  // battery above preconditioning threshold
      logic battery_temp_input_hi_ok;    // thermistor below 1.20 V
      logic battery_temp_input_lo_ok;    // thermistor above 0.25 V
      logic battery_temp_input_test;     // thermistor driven near supply (system test request)
      logic iset_open;      // current_set_enable floating
      logic term_done;      // termination current reached in constant voltage
      logic recharge;       // battery below recharge threshold
      logic at_reg;         // battery reached regulation voltage
   } chqf_cmp_t;
   localparam int CMP_W = $bits(chqf_cmp_t);

   typedef enum logic [3:0] {
      ST_SHUTDOWN, ST_STANDBY, ST_PRECOND, ST_FAST, ST_CV,
      ST_DONE, ST_TEMP_FAULT, ST_TIMER_FAULT, ST_SYS_TEST
   } chqf_state_t;

   // probe pulse timing: period in us and derived cycle count
   localparam int CLK_MHZ            = 100;
   localparam int PROBE_PERIOD_US    = 100;
   localparam int PROBE_CYCLES       = PROBE_PERIOD_US * CLK_MHZ;
   localparam int PROBE_W            = 14;
   // charge timer: tick of 1 ms, expiry in ticks (4 h nominal)
   localparam int TICK_US            = 1000;
   localparam int TICK_CYCLES        = TICK_US * CLK_MHZ;
   localparam int TICK_W             = 17;
   localparam int TIMER_W            = 24;
   localparam logic [23:0] TIMER_LIMIT = 24'hDBBA00;  // 14,400,000 ms
   localparam logic RST_OUT_OFF      = 1'b0;
endpackage

/* chqf_sync.sv */
// chqf_sync: two-flop synchroniser, one per comparator bit
// assumes: inputs asynchronous to i_clk_sys, no reset needed on data path
`timescale 1ns/100ps
module chqf_sync #(
   parameter int W = 1
) (
   // clock
   input  wire logic         i_clk_sys,
   // data
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] meta;

   // first flop is read only by the second
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         always_ff @(posedge i_clk_sys) begin
            meta[g]   <= i_async[g];
            o_sync[g] <= meta[g];
         end
      end
   endgenerate
endmodule
